/* rtl/csf_defines.vh */
// register offsets, field positions and reset values of the status-flag block
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CSF_ADDR_PSW      8'hd0
`define CSF_ADDR_WORK     8'he0
`define CSF_ADDR_AUX      8'hf0

// ------------------------------------------------------------
// status word bit positions
// ------------------------------------------------------------
`define CSF_BIT_CARRY     7
`define CSF_BIT_HALF      6
`define CSF_BIT_USER0     5
`define CSF_BIT_BANK_HI   4
`define CSF_BIT_BANK_LO   3
`define CSF_BIT_OVF       2
`define CSF_BIT_USER1     1
`define CSF_BIT_PARITY    0

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define CSF_RST_BYTE      8'h00
`define CSF_RST_BANK      2'b00
`define CSF_BANK_BASE_W   5

`endif

/* rtl/csf_status_flags.v */
// working register, auxiliary register and program status word of the cpu core
//
// What this block does
// - 8-bit read/write working data register, clears to 0x00 on reset.
// - ALU results with carry, half-carry, overflow or parity change update the status word.
// - 8-bit read/write auxiliary register for multiply/divide, clears to 0x00.
// - Carry flag bit 7 follows add carry, no-borrow, rotate-out one, compare non-negative.
// - Half-carry bit 6 set on BCD carry out of bit 3, else cleared.
// - Bits 5 and 1 are user read/write flags, reset 0, drive nothing.
// - Bank field bits 4:3 selects working registers at 00H, 08H, 10H or 18H.
// - Overflow bit 2 set when arithmetic overflows the working register, else cleared.
// - Parity bit 0 is read-only, 1 for odd count of ones in working register.

`include "csf_defines.vh"

module csf_status_flags (
  // clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // register port
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // alu result writes into the working and auxiliary registers
  input  wire       alu_work_we_i,
  input  wire [7:0] alu_work_i,
  input  wire       alu_aux_we_i,
  input  wire [7:0] alu_aux_i,
  // alu flag updates, each with its own enable
  input  wire       carry_we_i,
  input  wire       carry_i,
  input  wire       half_we_i,
  input  wire       half_i,
  input  wire       ovf_we_i,
  input  wire       ovf_i,
  // state seen by the core
  output reg  [7:0] alu_working_reg_o,
  output reg  [7:0] mul_div_aux_reg_o,
  output reg  [7:0] program_status_word_o,
  output reg  [4:0] bank_base_addr_o
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg  [7:0] work_r;
  reg  [7:0] work_nxt;
  reg  [7:0] aux_r;
  reg  [7:0] aux_nxt;
  reg        carry_r;
  reg        carry_nxt;
  reg        half_r;
  reg        half_nxt;
  reg        user0_r;
  reg        user0_nxt;
  reg  [1:0] bank_r;
  reg  [1:0] bank_nxt;
  reg        ovf_r;
  reg        ovf_nxt;
  reg        user1_r;
  reg        user1_nxt;

  wire       psw_wr  = reg_wr_i & (reg_addr_i == `CSF_ADDR_PSW);
  wire       work_wr = reg_wr_i & (reg_addr_i == `CSF_ADDR_WORK);
  wire       aux_wr  = reg_wr_i & (reg_addr_i == `CSF_ADDR_AUX);

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always @* begin
    // the core owns the datapath: its write lands over a same-cycle software write
    work_nxt = work_r;
    if (alu_work_we_i) begin
      work_nxt = alu_work_i;
    end else if (work_wr) begin
      work_nxt = reg_wdata_i;
    end
    aux_nxt = aux_r;
    if (alu_aux_we_i) begin
      aux_nxt = alu_aux_i;
    end else if (aux_wr) begin
      aux_nxt = reg_wdata_i;
    end
    carry_nxt = carry_r;
    half_nxt  = half_r;
    user0_nxt = user0_r;
    bank_nxt  = bank_r;
    ovf_nxt   = ovf_r;
    user1_nxt = user1_r;
    if (psw_wr) begin
      carry_nxt = reg_wdata_i[`CSF_BIT_CARRY];
      half_nxt  = reg_wdata_i[`CSF_BIT_HALF];
      user0_nxt = reg_wdata_i[`CSF_BIT_USER0];
      bank_nxt  = reg_wdata_i[`CSF_BIT_BANK_HI:`CSF_BIT_BANK_LO];
      ovf_nxt   = reg_wdata_i[`CSF_BIT_OVF];
      user1_nxt = reg_wdata_i[`CSF_BIT_USER1];
    end
    // flag updates come last so they override the software write bit by bit
    if (carry_we_i) begin
      carry_nxt = carry_i;
    end
    if (half_we_i) begin
      half_nxt = half_i;
    end
    if (ovf_we_i) begin
      ovf_nxt = ovf_i;
    end
  end

  // ------------------------------------------------------------
  // read select decode
  // ------------------------------------------------------------
  wire       psw_rd  = reg_rd_i & (reg_addr_i == `CSF_ADDR_PSW);
  wire       work_rd = reg_rd_i & (reg_addr_i == `CSF_ADDR_WORK);
  wire       aux_rd  = reg_rd_i & (reg_addr_i == `CSF_ADDR_AUX);

  // ------------------------------------------------------------
  // parity chains
  // ------------------------------------------------------------
  // one per-bit cell builds both views, so read and mirror parity agree
  wire [7:0] par_nxt_chain;
  wire [7:0] par_cur_chain;

  assign par_nxt_chain[0] = work_nxt[0];
  assign par_cur_chain[0] = work_r[0];

  genvar gi;
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_parity
      assign par_nxt_chain[gi] = par_nxt_chain[gi-1] ^ work_nxt[gi];
      assign par_cur_chain[gi] = par_cur_chain[gi-1] ^ work_r[gi];
    end
  endgenerate

  // parity of the next working value, so the output flop stays aligned with it
  wire       parity_nxt = par_nxt_chain[7];
  // parity of the current value, for software reads
  wire       parity_cur = par_cur_chain[7];

  // ------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------
  reg  [7:0] psw_nxt;
  reg  [7:0] psw_cur;

  always @* begin
    psw_nxt                                    = `CSF_RST_BYTE;
    psw_nxt[`CSF_BIT_CARRY]                    = carry_nxt;
    psw_nxt[`CSF_BIT_HALF]                     = half_nxt;
    psw_nxt[`CSF_BIT_USER0]                    = user0_nxt;
    psw_nxt[`CSF_BIT_BANK_HI:`CSF_BIT_BANK_LO] = bank_nxt;
    psw_nxt[`CSF_BIT_OVF]                      = ovf_nxt;
    psw_nxt[`CSF_BIT_USER1]                    = user1_nxt;
    psw_nxt[`CSF_BIT_PARITY]                   = parity_nxt;
  end

  // parity bit is read-only; no write path reaches it
  always @* begin
    psw_cur                                    = `CSF_RST_BYTE;
    psw_cur[`CSF_BIT_CARRY]                    = carry_r;
    psw_cur[`CSF_BIT_HALF]                     = half_r;
    psw_cur[`CSF_BIT_USER0]                    = user0_r;
    psw_cur[`CSF_BIT_BANK_HI:`CSF_BIT_BANK_LO] = bank_r;
    psw_cur[`CSF_BIT_OVF]                      = ovf_r;
    psw_cur[`CSF_BIT_USER1]                    = user1_r;
    psw_cur[`CSF_BIT_PARITY]                   = parity_cur;
  end

  // ------------------------------------------------------------
  // bank base decode
  // ------------------------------------------------------------
  // each bank is eight bytes wide
  reg  [4:0] bank_base_nxt;

  always @* begin
    case (bank_nxt)
      2'h0: begin
        bank_base_nxt = 5'h00;
      end
      2'h1: begin
        bank_base_nxt = 5'h08;
      end
      2'h2: begin
        bank_base_nxt = 5'h10;
      end
      2'h3: begin
        bank_base_nxt = 5'h18;
      end
      default: begin
        bank_base_nxt = 5'h00;
      end
    endcase
  end

  // ------------------------------------------------------------
  // read data select
  // ------------------------------------------------------------
  // unmapped or idle cycles return zero, so stale data never lingers
  reg  [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = `CSF_RST_BYTE;
    if (psw_rd) begin
      rdata_nxt = psw_cur;
    end else if (work_rd) begin
      rdata_nxt = work_r;
    end else if (aux_rd) begin
      rdata_nxt = aux_r;
    end
  end

  // ------------------------------------------------------------
  // architectural state
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      work_r  <= `CSF_RST_BYTE;
      aux_r   <= `CSF_RST_BYTE;
      carry_r <= 1'b0;
      half_r  <= 1'b0;
      user0_r <= 1'b0;
      bank_r  <= `CSF_RST_BANK;
      ovf_r   <= 1'b0;
      user1_r <= 1'b0;
    end else begin
      work_r  <= work_nxt;
      aux_r   <= aux_nxt;
      carry_r <= carry_nxt;
      half_r  <= half_nxt;
      user0_r <= user0_nxt;
      bank_r  <= bank_nxt;
      ovf_r   <= ovf_nxt;
      user1_r <= user1_nxt;
    end
  end

  // ------------------------------------------------------------
  // output mirrors
  // ------------------------------------------------------------
  // mirrors load the next values, so they always equal the state flops
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      alu_working_reg_o     <= `CSF_RST_BYTE;
      mul_div_aux_reg_o     <= `CSF_RST_BYTE;
      program_status_word_o <= `CSF_RST_BYTE;
      bank_base_addr_o      <= 5'h00;
    end else begin
      alu_working_reg_o     <= work_nxt;
      mul_div_aux_reg_o     <= aux_nxt;
      program_status_word_o <= psw_nxt;
      bank_base_addr_o      <= bank_base_nxt;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // data stand for exactly one cycle after the read strobe
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `CSF_RST_BYTE;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

endmodule // csf_status_flags

/* bench/csf_status_flags_sva.sv */
// port assertions of the status-flag block
module csf_status_flags_sva (
  input logic       clk_i, nrst_i, reg_wr_i, reg_rd_i, alu_work_we_i, alu_aux_we_i,
  input logic       carry_we_i, carry_i, half_we_i, half_i, ovf_we_i, ovf_i,
  input logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, alu_work_i, alu_working_reg_o,
  input logic [7:0] mul_div_aux_reg_o, program_status_word_o,
  input logic [4:0] bank_base_addr_o
);
  wire  [7:0] program_status_word = program_status_word_o;
  logic [7:0] wd_q;
  always_ff @(posedge clk_i) wd_q <= reg_wdata_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_PARITY: assert property (program_status_word[0] == ^alu_working_reg_o)
    else $error("parity bit wrong");
  AST_CARRY: assert property (carry_we_i |=> program_status_word[7] == $past(carry_i))
    else $error("carry not taken");
  AST_HALF: assert property (half_we_i ##1 1 |-> program_status_word[6] == $past(half_i))
    else $error("half carry not taken");
  AST_OVF: assert property (ovf_we_i |=> program_status_word[2] == $past(ovf_i))
    else $error("overflow not taken");
  AST_BANK: assert property (bank_base_addr_o == {program_status_word[4:3], 3'h0})
    else $error("bank base wrong");
  AST_SWPSW: assert property (reg_wr_i && reg_addr_i == 8'hd0 |=> {program_status_word[5:3], program_status_word[1]} == {wd_q[5:3], wd_q[1]})
    else $error("status write lost");
  AST_WORK: assert property (alu_work_we_i |=> alu_working_reg_o == $past(alu_work_i))
    else $error("core write lost");
  AST_HOLD: assert property (!alu_work_we_i && !(reg_wr_i && reg_addr_i == 8'he0) |=> $stable(alu_working_reg_o))
    else $error("working register moved");
  AST_AUXWR: assert property (reg_wr_i && reg_addr_i == 8'hf0 && !alu_aux_we_i |=> mul_div_aux_reg_o == wd_q)
    else $error("aux write lost");
  AST_RDWORK: assert property (reg_rd_i && reg_addr_i == 8'he0 |=> reg_rdata_o == $past(alu_working_reg_o))
    else $error("read data wrong");
  cover property (carry_we_i && reg_wr_i && reg_addr_i == 8'hd0);
  cover property (reg_rd_i && reg_addr_i == 8'hd0);
  cover property (program_status_word[4:3] == 2'b11);
endmodule // csf_status_flags_sva
bind csf_status_flags csf_status_flags_sva csf_status_flags_sva_i (.*);

/* bench/csf_alu_model.sv */
// behavioural core alu: adds two bytes, reports sum and flags for one cycle
module csf_alu_model (
  input  logic       clk_i, op_i,
  input  logic [7:0] a_i, b_i,
  output logic       we_o = 0, carry_o = 0, half_o = 0, ovf_o = 0,
  output logic [7:0] sum_o = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] s = a_i + b_i;
  always @(posedge clk_i) begin
    we_o <= op_i;
    if (op_i) begin
      {carry_o, sum_o} <= a_i + b_i;
      half_o <= ({1'b0, a_i[3:0]} + b_i[3:0]) > 5'h0f;
      ovf_o <= (a_i[7] == b_i[7]) && (s[7] != a_i[7]);
    end else
      // idle lines toggle so stale data never looks valid
      {carry_o, half_o, ovf_o, sum_o} <= ~{carry_o, half_o, ovf_o, sum_o};
  end
endmodule // csf_alu_model

/* bench/csf_status_flags_bench.sv */
// self-checking bench of the status-flag block
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; $display("Error %s exp %h got %h", nm, ex, got); end end
module csf_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 0, nrst_i = 0, wr = 0, rd = 0, op = 0, rd_q = 0, we, cy, hc, ov;
  logic [7:0] addr = 0, wd = 0, a = 0, b = 0, sum, rdata, work, aux, program_status_word, x;
  logic [4:0] base;
  logic [7:0] exq[$];
  int         errors = 0, n_compared = 0;
  always #4 clk_i = ~clk_i;
  csf_alu_model csf_alu_model_i (.clk_i, .op_i(op), .a_i(a), .b_i(b), .we_o(we), .carry_o(cy),
    .half_o(hc), .ovf_o(ov), .sum_o(sum));
  csf_status_flags csf_status_flags_i (.clk_i, .nrst_i, .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .alu_work_we_i(we), .alu_work_i(sum),
    .alu_aux_we_i(we), .alu_aux_i(sum), .carry_we_i(we), .carry_i(cy), .half_we_i(we), .half_i(hc),
    .ovf_we_i(we), .ovf_i(ov), .alu_working_reg_o(work), .mul_div_aux_reg_o(aux),
    .program_status_word_o(program_status_word), .bank_base_addr_o(base));
  task automatic cyc(input logic w, r, input logic [7:0] ad, dt);
    @(posedge clk_i);
    wr <= w;
    rd <= r;
    addr <= ad;
    wd <= dt;
  endtask
  task automatic rdx(input logic [7:0] ad, ex);
    cyc(0, 1, ad, 8'h00);
    exq.push_back(ex);
  endtask
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    rd_q <= rd;
    if (rd_q) begin x = exq.pop_front(); `CHK("rdata", x, rdata) end
  end
  initial begin
    logic [8:0] s;
    logic [7:0] p, q, v;
    logic       h, o;
    void'($urandom(32'h408c));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1;
    rdx(8'hd0, 8'h00);
    rdx(8'he0, 8'h00);
    rdx(8'hf0, 8'h00);
    cyc(1, 0, 8'hd1, 8'hff);
    rdx(8'hd1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      v[4:3] = ~k[1:0];
      cyc(1, 0, 8'he0, v);
      cyc(1, 0, 8'hf0, v);
      cyc(1, 0, 8'hd0, ~v);
      rdx(8'hd0, {~v[7:1], ^v});
      rdx(8'hf0, v);
      @(negedge clk_i);
      `CHK("base", {k[1:0], 3'h0}, base)
    end
    cyc(1, 0, 8'hd0, 8'h00);
    for (int k = 0; k < 16; k++) begin
      p = $urandom;
      q = $urandom;
      s = p + q;
      h = ({1'b0, p[3:0]} + q[3:0]) > 5'h0f;
      o = (p[7] == q[7]) && (s[7] != p[7]);
      cyc(0, 0, 8'h00, 8'h00);
      a <= p;
      b <= q;
      op <= 1;
      cyc(k[0], 0, 8'hd0, {~s[8], ~h, 3'b000, ~o, 2'b00});
      op <= 0;
      rdx(8'hd0, {s[8], h, 3'b000, o, 1'b0, ^s[7:0]});
      rdx(8'he0, s[7:0]);
      @(negedge clk_i);
      `CHK("psw", {s[8], h, 3'b000, o, 1'b0, ^s[7:0]}, program_status_word)
      `CHK("work", s[7:0], work)
      `CHK("aux", s[7:0], aux)
    end
    cyc(0, 0, 8'h00, 8'h00);
    repeat (3) @(posedge clk_i);
    stop_test;
  end
  // generous budget: the sequence needs about 100 cycles
  initial begin
    #20000;
    errors++;
    stop_test;
  end
endmodule // csf_status_flags_bench
